/* design/mie_core.sv */
`default_nettype none
module mie_core #(
	parameter int unsigned WORD_W  = 14,
	parameter int unsigned DATA_W  = 8,
	parameter int unsigned INDEX_W = 7
) (
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic [WORD_W-1:0]  instr,
	input  wire logic               instr_valid,
	input  wire logic [DATA_W-1:0]  reg_rdata,
	output logic      [INDEX_W-1:0] reg_index,
	output logic                    reg_wr,
	output logic      [INDEX_W-1:0] reg_wr_index_ff,
	output logic      [DATA_W-1:0]  reg_wdata_ff,
	output logic                    reg_wr_ff,
	output logic      [DATA_W-1:0]  accum_ff,
	output logic                    null_flag_ff,
	output logic                    done_ff,
	output logic                    unknown_ff
);

	// ------------------------------------------------------------
	// decoded strobes and next values
	// ------------------------------------------------------------
	mie_pkg::mie_ins_t  ins_class;
	logic               tsel;
	logic               is_copy_reg;
	logic               is_load_imm;
	logic               is_copy_acc;
	logic               is_idle;
	logic               is_other;
	logic [DATA_W-1:0]  imm_value;
	logic               nxt_reg_wr;
	logic [INDEX_W-1:0] nxt_reg_wr_index;
	logic [DATA_W-1:0]  nxt_reg_wdata;
	logic [DATA_W-1:0]  nxt_accum;
	logic               nxt_null_flag;
	logic               nxt_done;
	logic               nxt_unknown;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// true when the moved byte is all zero
	function automatic logic is_zero_byte(
		input logic [DATA_W-1:0] value
	);
		return (value == '0);
	endfunction : is_zero_byte

	// true when an instruction class writes the register file
	function automatic logic writes_register(
		input mie_pkg::mie_ins_t cls,
		input logic              sel
	);
		logic result;
		result = 1'b0;
		unique case (cls)
			mie_pkg::INS_COPY_REG: result = sel;
			mie_pkg::INS_COPY_ACC: result = 1'b1;
			default:               result = 1'b0;
		endcase
		return result;
	endfunction : writes_register

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// priority: copy, load, store, idle
	mie_decode #(
		.WORD_W (WORD_W)
	) u_decode (
		.instr       (instr),
		.instr_valid (instr_valid),
		.ins_class   (ins_class)
	);

	// ------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------
	assign tsel      = instr[mie_pkg::TSEL_POS];
	assign reg_index = instr[INDEX_W-1:0];
	assign imm_value = instr[DATA_W-1:0];
	// strobe kept low: writes go out through reg_wr_ff
	assign reg_wr    = 1'b0;

	// ------------------------------------------------------------
	// class strobes
	// ------------------------------------------------------------
	assign is_copy_reg = (ins_class == mie_pkg::INS_COPY_REG);
	assign is_load_imm = (ins_class == mie_pkg::INS_LOAD_IMM);
	assign is_copy_acc = (ins_class == mie_pkg::INS_COPY_ACC);
	assign is_idle     = (ins_class == mie_pkg::INS_IDLE);
	assign is_other    = (ins_class == mie_pkg::INS_OTHER);

	// ------------------------------------------------------------
	// accumulator next value
	// ------------------------------------------------------------
	always_comb begin
		nxt_accum = accum_ff;
		if (is_copy_reg && !tsel) begin
			nxt_accum = reg_rdata;
		end else if (is_load_imm) begin
			nxt_accum = imm_value;
		end else if (is_idle) begin
			nxt_accum = accum_ff;
		end
	end

	// ------------------------------------------------------------
	// accumulator register
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			accum_ff <= mie_pkg::ACCUM_RESET;
		end else begin
			accum_ff <= nxt_accum;
		end
	end

	// ------------------------------------------------------------
	// zero flag next value, register copy only
	// ------------------------------------------------------------
	always_comb begin
		nxt_null_flag = null_flag_ff;
		if (is_copy_reg) begin
			nxt_null_flag = is_zero_byte(reg_rdata);
		end
	end

	// ------------------------------------------------------------
	// zero flag register
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			null_flag_ff <= mie_pkg::NULLF_RESET;
		end else begin
			null_flag_ff <= nxt_null_flag;
		end
	end

	// ------------------------------------------------------------
	// write strobe
	// ------------------------------------------------------------
	// one cycle after execution
	assign nxt_reg_wr = writes_register(ins_class, tsel);

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_wr_ff <= 1'b0;
		end else begin
			reg_wr_ff <= nxt_reg_wr;
		end
	end

	// ------------------------------------------------------------
	// write address
	// ------------------------------------------------------------
	// held between writes so the file sees a steady bus
	always_comb begin
		nxt_reg_wr_index = reg_wr_index_ff;
		if (nxt_reg_wr) begin
			nxt_reg_wr_index = instr[INDEX_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_wr_index_ff <= '0;
		end else begin
			reg_wr_index_ff <= nxt_reg_wr_index;
		end
	end

	// ------------------------------------------------------------
	// write data
	// ------------------------------------------------------------
	// store takes the accumulator from before this edge
	always_comb begin
		nxt_reg_wdata = reg_wdata_ff;
		if (nxt_reg_wr && is_copy_acc) begin
			nxt_reg_wdata = accum_ff;
		end else if (nxt_reg_wr) begin
			nxt_reg_wdata = reg_rdata;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_wdata_ff <= '0;
		end else begin
			reg_wdata_ff <= nxt_reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// completion pulse
	// ------------------------------------------------------------
	// every accepted word finishes in one cycle
	assign nxt_done = instr_valid;

	always_ff @(posedge clock) begin
		if (rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= nxt_done;
		end
	end

	// ------------------------------------------------------------
	// unknown opcode pulse
	// ------------------------------------------------------------
	assign nxt_unknown = is_other;

	always_ff @(posedge clock) begin
		if (rst) begin
			unknown_ff <= 1'b0;
		end else begin
			unknown_ff <= nxt_unknown;
		end
	end

endmodule : mie_core
`default_nettype wire

/* include/mie_pkg.sv */
`default_nettype none
package mie_pkg;

	// ------------------------------------------------------------
	// instruction word layout
	// ------------------------------------------------------------
	localparam int unsigned WORD_W   = 14;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned INDEX_W  = 7;
	localparam int unsigned TSEL_POS = 7;

	// ------------------------------------------------------------
	// opcode patterns (upper bits compared; idle also compares the low five bits)
	// ------------------------------------------------------------
	localparam logic [5:0] OP_COPY_REG   = 6'h08; // 00 1000
	localparam logic [3:0] OP_LOAD_IMM   = 4'hc;  // 11 00xx
	localparam logic [6:0] OP_COPY_ACC   = 7'h01; // 00 0000 1
	localparam logic [6:0] OP_IDLE_HI    = 7'h00; // 00 0000 0
	localparam logic [4:0] OP_IDLE_LO    = 5'h00; // low five bits

	// ------------------------------------------------------------
	// reset values and execution cycle count
	// ------------------------------------------------------------
	localparam logic [7:0] ACCUM_RESET   = 8'h00;
	localparam logic       NULLF_RESET   = 1'b0;
	localparam int unsigned EXEC_CYCLES  = 1;

	// ------------------------------------------------------------
	// decoded instruction classes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		INS_NONE     = 3'h0,
		INS_COPY_REG = 3'h1,
		INS_LOAD_IMM = 3'h3,
		INS_COPY_ACC = 3'h2,
		INS_IDLE     = 3'h6,
		INS_OTHER    = 3'h7
	} mie_ins_t;

endpackage : mie_pkg
`default_nettype wire

/* design/mie_decode.sv */
`default_nettype none
module mie_decode #(
	parameter int unsigned WORD_W = 14
) (
	input  wire logic [WORD_W-1:0] instr,
	input  wire logic              instr_valid,
	output mie_pkg::mie_ins_t      ins_class
);

	// ------------------------------------------------------------
	// opcode classification
	// ------------------------------------------------------------
	always_comb begin
		ins_class = mie_pkg::INS_NONE;
		if (instr_valid) begin
			if (instr[13:8] == mie_pkg::OP_COPY_REG) begin
				ins_class = mie_pkg::INS_COPY_REG;
			end else if (instr[13:10] == mie_pkg::OP_LOAD_IMM) begin
				ins_class = mie_pkg::INS_LOAD_IMM;
			end else if (instr[13:7] == mie_pkg::OP_COPY_ACC) begin
				ins_class = mie_pkg::INS_COPY_ACC;
			end else if (instr[13:7] == mie_pkg::OP_IDLE_HI &&
				instr[4:0] == mie_pkg::OP_IDLE_LO) begin
				ins_class = mie_pkg::INS_IDLE;
			end else begin
				ins_class = mie_pkg::INS_OTHER;
			end
		end
	end

endmodule : mie_decode
`default_nettype wire

/* verif/mie_checker.sv */
`default_nettype none
// ----
// checks
// ----
module mie_chk (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [13:0] instr,
	input wire logic        instr_valid,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_wr_ff,
	input wire logic [7:0]  reg_wdata_ff,
	input wire logic [7:0]  accum_ff,
	input wire logic        null_flag_ff,
	input wire logic        done_ff
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire logic cp = instr_valid && instr[13:8] == 6'h08;
	wire logic ca = instr_valid && instr[13:7] == 7'h01;
	wire logic idle_instruction = instr_valid && instr[13:7] == 7'h00 && instr[4:0] == 5'h00;
	a_copy_accum: assert property (cp && !instr[7]
		|=> accum_ff == $past(reg_rdata)) else $error("copy accum");
	a_copy_back: assert property (cp && instr[7]
		|=> reg_wr_ff && reg_wdata_ff == $past(reg_rdata)) else $error("copy");
	a_zero_flag: assert property (cp
		|=> null_flag_ff == ($past(reg_rdata) == 8'h00)) else $error("flag");
	a_load_imm: assert property (instr_valid && instr[13:10] == 4'hc
		|=> accum_ff == 8'($past(instr)) && $stable(null_flag_ff))
		else $error("load");
	a_store_accum: assert property (ca
		|=> reg_wr_ff && reg_wdata_ff == $past(accum_ff) && $stable(null_flag_ff))
		else $error("store");
	a_idle_quiet: assert property (idle_instruction
		|=> !reg_wr_ff && $stable(accum_ff) && $stable(null_flag_ff))
		else $error("idle");
	a_done_pulse: assert property (instr_valid |=> done_ff) else $error("done");
	a_no_instr: assert property (!instr_valid
		|=> !done_ff && !reg_wr_ff) else $error("no instr");
endmodule : mie_chk
bind mie_core mie_chk u_chk (.clock, .rst, .instr, .instr_valid, .reg_rdata,
	.reg_wr_ff, .reg_wdata_ff, .accum_ff, .null_flag_ff, .done_ff);
`default_nettype wire

/* verif/mie_core_tb.sv */
`default_nettype none
// ----
// bench
// ----
module mie_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 0, rst = 1, instr_valid = 0;
	logic [13:0] instr = '0;
	logic [7:0]  reg_rdata = '0, reg_wdata_ff, accum_ff;
	logic [6:0]  reg_index, reg_wr_index_ff;
	logic        reg_wr, reg_wr_ff, null_flag_ff, done_ff, unknown_ff;
	int          failures = 0, comparisons = 0;
	mie_core dut (.clock, .rst, .instr, .instr_valid, .reg_rdata, .reg_index,
		.reg_wr, .reg_wr_index_ff, .reg_wdata_ff, .reg_wr_ff, .accum_ff,
		.null_flag_ff, .done_ff, .unknown_ff);
	always #20 clock = ~clock;
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic run(logic [13:0] w, logic [7:0] d);
		@(posedge clock);
		instr <= w;
		instr_valid <= 1'b1;
		reg_rdata <= d;
		@(posedge clock);
		instr_valid <= 1'b0;
		reg_rdata <= ~d;
		#1;
		chk("done", 8'h01, 8'(done_ff));
	endtask : run
	task automatic t_copy;
		run(14'h0805, 8'h81);
		chk("accum", 8'h81, accum_ff);
		chk("wr", 8'h00, 8'(reg_wr_ff));
		run(14'h0885, 8'h00);
		chk("wdata", 8'h00, reg_wdata_ff);
		chk("index", 8'h05, 8'(reg_wr_index_ff));
		chk("flag", 8'h01, 8'(null_flag_ff));
	endtask : t_copy
	task automatic t_load;
		for (int i = 0; i < 4; i++) begin
			run({4'hc, i[1:0], 8'h5a + 8'(i)}, 8'h00);
			chk("accum", 8'h5a + 8'(i), accum_ff);
			chk("flag", 8'h01, 8'(null_flag_ff));
		end
	endtask : t_load
	task automatic t_store;
		run(14'h00ff, 8'h00);
		chk("index", 8'h7f, 8'(reg_wr_index_ff));
		chk("rindex", 8'h7f, 8'(reg_index));
		chk("wdata", 8'h5d, reg_wdata_ff);
	endtask : t_store
	task automatic t_idle;
		run(14'h0060, 8'h00);
		chk("wr", 8'h00, 8'(reg_wr_ff));
		chk("accum", 8'h5d, accum_ff);
		chk("unknown", 8'h00, 8'(unknown_ff));
	endtask : t_idle
	task automatic t_other;
		run(14'h3f00, 8'h00);
		chk("unknown", 8'h01, 8'(unknown_ff));
		chk("accum", 8'h5d, accum_ff);
		chk("strobe", 8'h00, 8'(reg_wr));
	endtask : t_other
	task automatic close_out;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		t_copy();
		t_load();
		t_store();
		t_idle();
		t_other();
		close_out();
	end
endmodule : mie_core_tb
`default_nettype wire
